// File: acc_core.sv
// Converter control: selector decode, control register A, divider and sequencer.
`timescale 1ns/1ns

// Operation
// - Selector change applies when conversion completes
// - Codes 0-7 single inputs, ground, reference
// - Code 100010 selects temperature sensor
// - Normal and reversed differential code ranges
// - Lowest selector bit picks gain 1x/20x on differential and calibration codes
// - Top selector bit swaps differential polarity
// - Differential codes decode to documented pin pairs
// - Calibration codes tie one pin both sides
// - Enable powers converter; clearing aborts conversion
// - Start bit begins single or first conversion
// - First conversion 25 cycles, later 13
// - Start reads one while converting; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag sets when result updated
// - Interrupt while flag, enable, global enable
// - Flag clears on vector or write one
// - Divider select gives 2..128 converter clock
// - Trigger source zero free running, else events
module acc_core (
  input  wire logic                 clk_sys_i,     // System clock, 250 MHz.
  input  wire logic                 rst_i,         // Synchronous reset, active high.
  input  wire logic [7:0]           addr_i,        // Register address.
  input  wire logic [7:0]           wdata_i,       // Write data.
  input  wire logic                 wr_i,          // Write strobe.
  input  wire logic                 rd_i,          // Read strobe.
  output logic      [7:0]           rdata_o,       // Read data, cycle after rd_i.
  input  wire logic                 global_irq_en_i, // Processor global interrupt enable.
  input  wire logic                 irq_ack_i,     // Interrupt vector taken pulse.
  input  wire logic [6:0]           trig_events_i, // Trigger event flags for sources 1..7.
  input  wire logic [9:0]           sample_i,      // Analog core result at end of conversion.
  output logic                      irq_o,         // Conversion done interrupt request.
  output logic                      powered_o,     // Analog core powered.
  output logic                      sampling_o,    // Conversion in progress.
  output logic                      conv_tick_o,   // Converter clock enable pulse.
  output acc_pkg::acc_route_type    route_o        // Front-end routing in force.
);
  import acc_pkg::*;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [5:0] sel_q;        // Selector as written by software.
  logic [5:0] sel_act_q;    // Selector in force for the analog path.
  logic [1:0] refsel_q;     // Reference select bits, stored only.
  logic       en_q;         // Converter enable.
  logic       auto_q;       // Auto trigger enable.
  logic       done_q;       // Conversion done flag.
  logic       irq_en_q;     // Done interrupt enable.
  logic [2:0] div_q;        // Clock divider select.
  logic [2:0] trig_src_q;   // Trigger source select.
  logic [9:0] result_q;     // Last result.
  logic [6:0] prescale_q;   // Free running prescaler.
  logic [4:0] cyc_q;        // Converter cycles left.
  logic       fresh_q;      // Next conversion is the first after enabling.
  logic       busy_q;       // Conversion in progress.
  logic [6:0] ev_s1_q;      // Trigger synchroniser first stage.
  logic [6:0] ev_s2_q;      // Trigger synchroniser second stage.
  logic       trig_lvl_q;   // Previous selected trigger level.
  logic       tick;         // Converter clock enable.
  logic       trig_lvl;     // Selected trigger level.
  logic       start_req;    // Conversion start request.
  logic       finish;       // Conversion ends this cycle.
  logic       wr_a;         // Write to control A.
  logic       done_set;     // Completion event.

  assign wr_a = wr_i && (addr_i == ACC_CONTROL_A_OFFSET);
  assign finish = busy_q && tick && (cyc_q == 5'd1);
  assign done_set = finish;

  // ****************************************************************
  // Prescaler: codes 0 and 1 divide by two, each further code doubles.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_q) begin
      prescale_q <= 7'h00; // Stopped while disabled saves power.
    end else begin
      prescale_q <= prescale_q + 7'h01;
    end
  end

  // A tick fires when the low k bits of the prescaler are all ones.
  always_comb begin
    logic [6:0] mask;
    mask = 7'h01;
    if (div_q > 3'h1) begin
      mask = 7'((8'h01 << div_q) - 8'h01);
    end
    tick = en_q && ((prescale_q & mask) == mask);
  end
  assign conv_tick_o = tick;

  // ****************************************************************
  // Trigger synchroniser and edge detect; events come from pins.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ev_s1_q <= 7'h00;
      ev_s2_q <= 7'h00;
    end else begin
      ev_s1_q <= trig_events_i;
      ev_s2_q <= ev_s1_q;
    end
  end

  // Source zero has no edge; a done flag never triggers it on selection.
  assign trig_lvl = (trig_src_q == ACC_FREE_RUN_SRC) ? 1'b0 :
                    ev_s2_q[3'(trig_src_q - 3'h1)];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trig_lvl_q <= 1'b0;
    end else begin
      trig_lvl_q <= trig_lvl;
    end
  end

  // Start: written start bit, a rising trigger edge, or free-running restart.
  assign start_req = (wr_a && wdata_i[ACC_START_BIT] && wdata_i[ACC_ENABLE_BIT])
                   || (en_q && auto_q && trig_lvl && !trig_lvl_q)
                   || (finish && auto_q && trig_src_q == ACC_FREE_RUN_SRC);

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cyc_q <= 5'h00;
      fresh_q <= 1'b1;
    end else if (wr_a && !wdata_i[ACC_ENABLE_BIT]) begin
      busy_q <= 1'b0;
      cyc_q <= 5'h00;
      fresh_q <= 1'b1;
    end else if (start_req && (!busy_q || finish)) begin
      busy_q <= 1'b1;
      cyc_q <= fresh_q ? ACC_FIRST_CYCLES : ACC_NORMAL_CYCLES;
      fresh_q <= 1'b0;
    end else if (finish) begin
      busy_q <= 1'b0;
      cyc_q <= 5'h00;
    end else if (busy_q && tick) begin
      cyc_q <= cyc_q - 5'h01;
    end
  end

  // ****************************************************************
  // Control register A and flag; set wins over any clear.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      en_q <= ACC_CONTROL_A_RESET[ACC_ENABLE_BIT];
      auto_q <= ACC_CONTROL_A_RESET[ACC_AUTO_BIT];
      irq_en_q <= ACC_CONTROL_A_RESET[ACC_IRQ_EN_BIT];
      div_q <= ACC_CONTROL_A_RESET[2:0];
      done_q <= ACC_CONTROL_A_RESET[ACC_DONE_BIT];
    end else begin
      if (wr_a) begin
        en_q <= wdata_i[ACC_ENABLE_BIT];
        auto_q <= wdata_i[ACC_AUTO_BIT];
        irq_en_q <= wdata_i[ACC_IRQ_EN_BIT];
        div_q <= wdata_i[2:0];
      end
      if (done_set) begin
        done_q <= 1'b1;
      end else if (irq_ack_i || (wr_a && wdata_i[ACC_DONE_BIT])) begin
        done_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Selector, control B and result; selector applies between conversions.
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_q <= ACC_SELECTOR_RESET;
      sel_act_q <= ACC_SELECTOR_RESET;
      refsel_q <= 2'h0;
      trig_src_q <= 3'h0;
      result_q <= 10'h000;
    end else begin
      if (wr_i && addr_i == ACC_SELECTOR_OFFSET) begin
        sel_q <= wdata_i[5:0];
        refsel_q <= wdata_i[7:6];
      end
      if (wr_i && addr_i == ACC_CONTROL_B_OFFSET) begin
        trig_src_q <= wdata_i[2:0];
      end
      // Held while busy so a mid-conversion write waits for completion.
      if (!busy_q || finish) begin
        sel_act_q <= (wr_i && addr_i == ACC_SELECTOR_OFFSET) ? wdata_i[5:0] : sel_q;
      end
      if (finish) begin
        result_q <= sample_i;
      end
    end
  end

  // ****************************************************************
  // Selector decode into analog routing.
  // ****************************************************************
  always_comb begin
    logic [4:0] pair;
    logic [2:0] p;
    logic [2:0] n;
    pair = 5'(sel_act_q[4:1] - 4'h4);
    p = 3'h0;
    n = 3'h0;
    route_o = '0;
    route_o.gain20 = sel_act_q[ACC_GAIN_BIT];
    if (sel_act_q[5:3] == 3'h0) begin
      route_o.kind = ACC_SRC_SINGLE;
      route_o.pos_pin = sel_act_q[2:0];
      route_o.gain20 = 1'b0;
    end else if (sel_act_q == ACC_GROUND_CODE) begin
      route_o.kind = ACC_SRC_GROUND;
      route_o.gain20 = 1'b0;
    end else if (sel_act_q == ACC_BANDGAP_CODE) begin
      route_o.kind = ACC_SRC_BANDGAP;
      route_o.gain20 = 1'b0;
    end else if (sel_act_q == ACC_TEMP_CODE) begin
      route_o.kind = ACC_SRC_TEMP;
      route_o.pos_pin = 3'h0;
      route_o.temp_en = 1'b1;
      route_o.gain20 = 1'b0;
    end else if (sel_act_q[5:1] == ACC_CAL3_CODE[5:1] || sel_act_q[5:1] == ACC_CAL7_CODE[5:1]
                 || sel_act_q == ACC_CAL0_CODE) begin
      route_o.kind = ACC_SRC_DIFF;
      p = (sel_act_q == ACC_CAL0_CODE) ? 3'h0 : (sel_act_q[2] && sel_act_q[1]) ? 3'h7 : 3'h3;
      route_o.pos_pin = p;
      route_o.neg_pin = p;
    end else begin
      // Twelve pairs in order, index = code[4:1] - 4 (codes 001000 to 011111).
      pair = 5'(sel_act_q[4:1]) - 5'h04;
      case (pair[3:0])
        4'h0: begin p = 3'h0; n = 3'h1; end
        4'h1: begin p = 3'h0; n = 3'h3; end
        4'h2: begin p = 3'h1; n = 3'h2; end
        4'h3: begin p = 3'h1; n = 3'h3; end
        4'h4: begin p = 3'h2; n = 3'h3; end
        4'h5: begin p = 3'h3; n = 3'h4; end
        4'h6: begin p = 3'h3; n = 3'h5; end
        4'h7: begin p = 3'h3; n = 3'h6; end
        4'h8: begin p = 3'h3; n = 3'h7; end
        4'h9: begin p = 3'h4; n = 3'h5; end
        4'ha: begin p = 3'h5; n = 3'h6; end
        4'hb: begin p = 3'h6; n = 3'h7; end
        default: begin p = 3'h0; n = 3'h0; end
      endcase
      route_o.kind = ACC_SRC_DIFF;
      route_o.pos_pin = sel_act_q[ACC_SWAP_BIT] ? n : p;
      route_o.neg_pin = sel_act_q[ACC_SWAP_BIT] ? p : n;
    end
  end

  // ****************************************************************
  // Outputs and read port.
  // ****************************************************************
  assign irq_o = done_q && irq_en_q && global_irq_en_i;
  assign powered_o = en_q;
  assign sampling_o = busy_q;

  // Unmapped addresses read as zero.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ACC_SELECTOR_OFFSET: rdata_o <= {refsel_q, sel_q};
        ACC_CONTROL_A_OFFSET: rdata_o <= {en_q, busy_q, auto_q, done_q, irq_en_q, div_q};
        ACC_CONTROL_B_OFFSET: rdata_o <= {5'h00, trig_src_q};
        ACC_RESULT_LO_OFFSET: rdata_o <= result_q[7:0];
        ACC_RESULT_HI_OFFSET: rdata_o <= {6'h00, result_q[9:8]};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  done_sets_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    finish |=> done_q) else $error("done flag not set on completion");
  abort_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_a && !wdata_i[ACC_ENABLE_BIT]) |=> !busy_q) else $error("disable did not abort");
  first_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_req && fresh_q && !busy_q && !(wr_a && !wdata_i[ACC_ENABLE_BIT]))
    |=> cyc_q == ACC_FIRST_CYCLES) else $error("first conversion not 25 cycles");
  // A completion with the enable held must raise the request whenever the global enable is on.
  irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_set && irq_en_q && !wr_a) |=> (irq_o == global_irq_en_i))
    else $error("interrupt not raised on completion");
  sel_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (busy_q && !finish) |=> $stable(sel_act_q)) else $error("selector changed mid conversion");
  flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (irq_ack_i && !done_set) |=> !done_q) else $error("flag not cleared by ack");
  // A disable written in the completing cycle wins over the restart, so it is left out.
  free_run_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (finish && auto_q && trig_src_q == ACC_FREE_RUN_SRC && !(wr_a && !wdata_i[ACC_ENABLE_BIT]))
    |=> busy_q) else $error("free running did not restart");
  temp_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (sel_act_q == ACC_TEMP_CODE) |-> route_o.temp_en) else $error("temp sensor off");
  conv_done_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) finish);
  free_run_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    finish && auto_q && trig_src_q == ACC_FREE_RUN_SRC);
  abort_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    busy_q && wr_a && !wdata_i[ACC_ENABLE_BIT]);

endmodule

// File: acc_core_tb_top.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ns
module acc_core_tb_top;
  import acc_pkg::*;

  // ****************************************************************
  // Stimulus signals and bookkeeping.
  // ****************************************************************
  logic          clk_sys_i       = 1'b0;   // System clock, 4 ns period.
  logic          rst_i           = 1'b1;   // Synchronous reset.
  logic [7:0]    addr_i          = 8'h00;  // Register address.
  logic [7:0]    wdata_i         = 8'h00;  // Write data.
  logic          wr_i            = 1'b0;   // Write strobe.
  logic          rd_i            = 1'b0;   // Read strobe.
  logic          global_irq_en_i = 1'b0;   // Global interrupt enable.
  logic          irq_ack_i       = 1'b0;   // Vector taken pulse.
  logic [6:0]    trig_events_i   = 7'h00;  // Trigger event levels.
  logic [9:0]    sample_i        = 10'h2a5; // Fixed result so both bytes differ.
  logic [7:0]    rdata_o;                  // Read data.
  logic          irq_o;                    // Interrupt request.
  logic          powered_o;                // Analog core powered.
  logic          sampling_o;               // Conversion busy.
  logic          conv_tick_o;              // Converter clock enable.
  acc_route_type route_o;                  // Routing in force.
  int            fails           = 0;      // Mismatches seen.
  int            samples_checked = 0;      // Comparisons made.
  int            cycles          = 0;      // Cycles since time zero.

  // Differential and calibration codes with their {pos, neg, gain} decode.
  localparam logic [5:0] DIFF_CODES [14] = '{6'h08, 6'h09, 6'h0a, 6'h10, 6'h1a, 6'h1f,
    6'h28, 6'h3b, 6'h3f, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27};
  localparam logic [6:0] DIFF_PINS [14] = '{7'h02, 7'h03, 7'h06, 7'h26, 7'h4a, 7'h6f,
    7'h10, 7'h59, 7'h7d, 7'h01, 7'h36, 7'h37, 7'h7e, 7'h7f};

  always #2 clk_sys_i = ~clk_sys_i;

  acc_core dut (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (rst_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .global_irq_en_i (global_irq_en_i),
    .irq_ack_i       (irq_ack_i),
    .trig_events_i   (trig_events_i),
    .sample_i        (sample_i),
    .irq_o           (irq_o),
    .powered_o       (powered_o),
    .sampling_o      (sampling_o),
    .conv_tick_o     (conv_tick_o),
    .route_o         (route_o)
  );

  // ****************************************************************
  // Bus, comparison and closing tasks.
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A write occupies one cycle; the strobe drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 check(16'(rdata_o), 16'(exp), msg);
  endtask

  // Bounded wait for the busy output to reach a level.
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    #1;
    while (sampling_o !== v && n < lim) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    check(16'(sampling_o), 16'(v), "busy level not reached in time");
  endtask

  // Counts ticks standing in busy cycles, looked at 1 ns after each edge.
  task automatic conv_ticks(input int exp, input string msg);
    int n;
    int g;
    n = 0;
    g = 0;
    wait_busy(1'b1, 20);
    while (sampling_o === 1'b1 && g < 600) begin
      if (conv_tick_o === 1'b1) n++;
      @(posedge clk_sys_i);
      #1 g++;
    end
    check(16'(n), 16'(exp), msg);
  endtask

  // Writes a selector code and compares the routing that is put in force.
  task automatic sel_case(input logic [5:0] code, input acc_src_type k, input logic [6:0] png);
    // Reference bits stay at zero, so no settling wait for the internal reference is owed.
    wr(ACC_SELECTOR_OFFSET, {2'b00, code});
    @(posedge clk_sys_i);
    #1 check(16'(route_o.kind), 16'(k), "route kind");
    check(16'(route_o.temp_en), 16'(k == ACC_SRC_TEMP), "temperature enable");
    if (k == ACC_SRC_SINGLE || k == ACC_SRC_DIFF) begin
      check(16'(route_o.pos_pin), 16'(png[6:4]), "positive pin");
    end
    if (k == ACC_SRC_DIFF) begin
      check(16'(route_o.neg_pin), 16'(png[3:1]), "negative pin");
      check(16'(route_o.gain20), 16'(png[0]), "gain select");
    end
  endtask

  // The run needs well under 10000 cycles; the ceiling leaves twice that.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk(ACC_CONTROL_A_OFFSET, 8'h00, "control reset value");
    rd_chk(ACC_SELECTOR_OFFSET, 8'h00, "selector reset value");
    check(16'(route_o.kind), 16'(ACC_SRC_SINGLE), "reset route");
    check(16'(powered_o), 16'h0, "powered after reset");
    wr(8'h01, 8'hff);
    rd_chk(8'h01, 8'h00, "unmapped place reads zero");
    $display("Test reset finished");
    for (int i = 0; i < 8; i++) sel_case(6'(i), ACC_SRC_SINGLE, {3'(i), 4'h0});
    sel_case(ACC_GROUND_CODE, ACC_SRC_GROUND, 7'h00);
    sel_case(ACC_BANDGAP_CODE, ACC_SRC_BANDGAP, 7'h00);
    sel_case(ACC_TEMP_CODE, ACC_SRC_TEMP, 7'h00);
    for (int i = 0; i < 14; i++) sel_case(DIFF_CODES[i], ACC_SRC_DIFF, DIFF_PINS[i]);
    $display("Test selector decode finished");
    // First conversion after enabling carries initialisation, later ones do not.
    sel_case(6'h03, ACC_SRC_SINGLE, 7'h30);
    wr(ACC_CONTROL_A_OFFSET, 8'hc0);
    conv_ticks(25, "first conversion length");
    rd_chk(ACC_CONTROL_A_OFFSET, 8'h90, "done set, start cleared");
    rd_chk(ACC_RESULT_LO_OFFSET, 8'ha5, "result low byte");
    rd_chk(ACC_RESULT_HI_OFFSET, 8'h02, "result high bits");
    wr(ACC_CONTROL_A_OFFSET, 8'hd0);
    conv_ticks(13, "later conversion length");
    // A selector change in mid-conversion waits; writing start zero changes nothing.
    wr(ACC_CONTROL_A_OFFSET, 8'hc0);
    wr(ACC_SELECTOR_OFFSET, 8'h05);
    wr(ACC_CONTROL_A_OFFSET, 8'h80);
    #1 check(16'(sampling_o), 16'h1, "start zero aborted conversion");
    check(16'(route_o.pos_pin), 16'h3, "selector applied too early");
    rd_chk(ACC_CONTROL_A_OFFSET, 8'hd0, "start reads one while busy");
    wait_busy(1'b0, 200);
    check(16'(route_o.pos_pin), 16'h5, "selector not applied at completion");
    $display("Test conversion finished");
    // Interrupt follows flag, enable and global enable; ack and write one clear it.
    wr(ACC_CONTROL_A_OFFSET, 8'h88);
    @(posedge clk_sys_i) global_irq_en_i <= 1'b1;
    #1 check(16'(irq_o), 16'h1, "interrupt missing");
    @(posedge clk_sys_i) global_irq_en_i <= 1'b0;
    #1 check(16'(irq_o), 16'h0, "interrupt without global enable");
    @(posedge clk_sys_i) global_irq_en_i <= 1'b1;
    @(posedge clk_sys_i) irq_ack_i <= 1'b1;
    @(posedge clk_sys_i) irq_ack_i <= 1'b0;
    #1 check(16'(irq_o), 16'h0, "ack left interrupt");
    rd_chk(ACC_CONTROL_A_OFFSET, 8'h88, "ack left flag");
    wr(ACC_CONTROL_A_OFFSET, 8'hc8);
    wait_busy(1'b0, 200);
    check(16'(irq_o), 16'h1, "interrupt after completion");
    wr(ACC_CONTROL_A_OFFSET, 8'h98);
    rd_chk(ACC_CONTROL_A_OFFSET, 8'h88, "write one left flag");
    check(16'(irq_o), 16'h0, "interrupt after flag clear");
    $display("Test interrupt finished");
    // Disabling in mid-conversion aborts it; the next conversion is long again.
    wr(ACC_CONTROL_A_OFFSET, 8'hc0);
    #1 check(16'(powered_o), 16'h1, "not powered");
    repeat (6) @(posedge clk_sys_i);
    wr(ACC_CONTROL_A_OFFSET, 8'h00);
    @(posedge clk_sys_i);
    #1 check(16'(sampling_o), 16'h0, "abort failed");
    check(16'(powered_o), 16'h0, "still powered");
    rd_chk(ACC_CONTROL_A_OFFSET, 8'h00, "aborted conversion completed");
    wr(ACC_CONTROL_A_OFFSET, 8'hc0);
    conv_ticks(25, "first length after re-enable");
    $display("Test abort finished");
    // Every divider code; a 256-cycle window holds a whole number of periods.
    for (int d = 0; d < 8; d++) begin
      int n;
      wr(ACC_CONTROL_A_OFFSET, {5'h10, 3'(d)});
      repeat (130) @(posedge clk_sys_i);
      n = 0;
      repeat (256) begin
        @(posedge clk_sys_i);
        #1 if (conv_tick_o === 1'b1) n++;
      end
      check(16'(n), 16'(256 / ((d < 2) ? 2 : (1 << d))), "tick rate");
    end
    $display("Test divider finished");
    // Each trigger source starts on its own rising edge and ignores the others.
    wr(ACC_CONTROL_A_OFFSET, 8'h00);
    wr(ACC_CONTROL_A_OFFSET, 8'ha0);
    for (int s = 1; s < 8; s++) begin
      wr(ACC_CONTROL_B_OFFSET, {5'h00, 3'(s)});
      @(posedge clk_sys_i) trig_events_i <= ~(7'h01 << (s - 1));
      repeat (8) @(posedge clk_sys_i);
      #1 check(16'(sampling_o), 16'h0, "wrong source started");
      @(posedge clk_sys_i) trig_events_i <= 7'h7f;
      wait_busy(1'b1, 8);
      wait_busy(1'b0, 200);
      @(posedge clk_sys_i) trig_events_i <= 7'h00;
      repeat (4) @(posedge clk_sys_i);
    end
    $display("Test trigger finished");
    // Free running: the second conversion starts alone and is running at 60 cycles.
    wr(ACC_CONTROL_B_OFFSET, {5'h00, ACC_FREE_RUN_SRC});
    wr(ACC_CONTROL_A_OFFSET, 8'h00);
    wr(ACC_CONTROL_A_OFFSET, 8'he0);
    repeat (60) @(posedge clk_sys_i);
    rd_chk(ACC_CONTROL_A_OFFSET, 8'hf0, "no restart in free running");
    wr(ACC_CONTROL_A_OFFSET, 8'h00);
    repeat (60) @(posedge clk_sys_i);
    #1 check(16'(sampling_o), 16'h0, "free running kept on");
    $display("Test free running finished");
    stop_test();
  end
endmodule

// File: acc_pkg.sv
// Package with register map, field positions and decode types of the converter control.
package acc_pkg;

  // ****************************************************************
  // Register map and field positions.
  // ****************************************************************
  localparam logic [7:0] ACC_SELECTOR_OFFSET = 8'h07; // Input selector register.
  localparam logic [7:0] ACC_CONTROL_A_OFFSET = 8'h06; // Converter control A.
  localparam logic [7:0] ACC_CONTROL_B_OFFSET = 8'h03; // Converter control B (trigger source).
  localparam logic [7:0] ACC_RESULT_LO_OFFSET = 8'h04; // Result low byte.
  localparam logic [7:0] ACC_RESULT_HI_OFFSET = 8'h05; // Result high byte.
  localparam logic [7:0] ACC_CONTROL_A_RESET = 8'h00; // Control A reset value.
  localparam logic [5:0] ACC_SELECTOR_RESET = 6'h00; // Selector reset value.
  localparam int ACC_ENABLE_BIT = 7; // Converter enable.
  localparam int ACC_START_BIT = 6; // Conversion start.
  localparam int ACC_AUTO_BIT = 5; // Auto trigger enable.
  localparam int ACC_DONE_BIT = 4; // Conversion done flag.
  localparam int ACC_IRQ_EN_BIT = 3; // Done interrupt enable.
  localparam int ACC_GAIN_BIT = 0; // Gain select bit of the selector.
  localparam int ACC_SWAP_BIT = 5; // Polarity swap bit of the selector.

  // ****************************************************************
  // Timing constants in converter clock cycles, and the free-running trigger source code.
  // ****************************************************************
  localparam logic [4:0] ACC_FIRST_CYCLES = 5'd25; // First conversion with initialisation.
  localparam logic [4:0] ACC_NORMAL_CYCLES = 5'd13; // Normal conversion.
  localparam logic [2:0] ACC_FREE_RUN_SRC = 3'h0; // Trigger source code for free running.

  // ****************************************************************
  // Selector code landmarks.
  // ****************************************************************
  localparam logic [5:0] ACC_GROUND_CODE = 6'h20; // Analog ground.
  localparam logic [5:0] ACC_BANDGAP_CODE = 6'h21; // Internal 1.1 V reference.
  localparam logic [5:0] ACC_TEMP_CODE = 6'h22; // Temperature sensor channel.
  localparam logic [5:0] ACC_CAL0_CODE = 6'h23; // Input 0 offset calibration.
  localparam logic [5:0] ACC_CAL3_CODE = 6'h24; // Input 3 offset calibration (even).
  localparam logic [5:0] ACC_CAL7_CODE = 6'h26; // Input 7 offset calibration (even).
  localparam logic [5:0] ACC_DIFF_LO = 6'h08; // First normal differential code.
  localparam logic [5:0] ACC_DIFF_HI = 6'h1f; // Last normal differential code.
  localparam logic [5:0] ACC_REV_LO = 6'h28; // First reversed differential code.

  // Kind of input connection the selector makes.
  typedef enum logic [2:0] {
    ACC_SRC_SINGLE, ACC_SRC_GROUND, ACC_SRC_BANDGAP, ACC_SRC_TEMP, ACC_SRC_DIFF
  } acc_src_type;

  // Decoded analog front-end routing.
  typedef struct packed {
    acc_src_type kind;    // Connection kind.
    logic [2:0]  pos_pin; // Positive input pin.
    logic [2:0]  neg_pin; // Negative input pin (differential only).
    logic        gain20;  // Twenty-fold gain selected.
    logic        temp_en; // Temperature sensor enabled.
  } acc_route_type;

endpackage
